//--- design/mcse_status_encoder.sv
// Machine-check bank 4 status encoder with an Avalon-MM register slave
//
// What this block does
// [RL1] One shared info field in bits 56:32
// [RL2] Correctable count 39:32, starts 0, saturates 255
// [RL3] Bits 41:40 give extra-info layout, two values
// [RL4] Syndrome in 51:44 for correctable ECC
// [RL5] Bit 52 set only when syndrome supplied
// [RL6] Health in 54:53: none, green, yellow, reserved
// [RL7] Health valid with bit 63, undefined if uncorrected
// [RL8] Cache code: 18:16 code, zeros, fixed pattern
// [RL9] Codes 000/100 none, 001/010/011 multi-way
// [RL10] Codes 101/110 for single-way events
// [RL11] Code 111 for mixed correctable and uncorrectable
// [RL12] Bus bits 16,17,18,20; bit 19 reserved
// [RL13] Bus data parity bits 21, 22, 23
// [RL14] Defer parity bit 24, inbound ECC 25
// [RL15] Strobe glitch bits 26, 27; 31:28 reserved
// [RL16] Exactly one bus source bit per error
// [RL17] Only inbound data ECC may be correctable
// [RL18] Reserved bits read zero, ignore writes
// [RL19] Bit 61 is the uncorrected flag
// [RL20] Bit 59 flags valid extra-info register
//
// The Avalon-MM register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module mcse_status_encoder
   import mcse_pkg::*;
#(
   parameter int WAYS = 8
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Error report from detection units
   input wire logic err_valid,
   input wire mcse_kind_e err_kind,
   input wire logic [WAYS-1:0] cache_way_corr,
   input wire logic [WAYS-1:0] cache_way_uncorr,
   input wire logic [WAYS-1:0] cache_way_tag_hit,
   input wire logic [3:0] bus_src,
   input wire logic bus_corrected,
   input wire logic syn_valid,
   input wire logic [7:0] syn_value,
   input wire logic extra_info_valid,
   input wire logic [1:0] extra_info_format,
   input wire logic [1:0] health_in,
   // Assembled status
   output logic [63:0] bank4_error_status
);
   // Logged contents
   logic val_reg;
   logic uc_reg;
   logic extra_info_valid_reg;
   logic synv_reg;
   logic [1:0] fmt_reg;
   logic [7:0] syn_reg;
   logic [1:0] health_reg;
   logic [15:0] msc_reg;
   logic [7:0] count_reg;
   logic [31:0] ctrl_reg;
   // Bus slave
   logic ack_reg;
   logic [31:0] rdata_reg;

   logic [2:0] cache_code;
   logic cache_none;
   logic cache_corr;
   logic src_ok;
   logic src_ecc;
   logic [15:0] bus_msc;
   logic [15:0] cache_msc;
   logic accept;
   logic new_uc;
   logic new_synv;
   logic new_extra_info_valid;
   logic [1:0] new_health;
   logic overwrite;
   logic bus_req;
   logic bus_take;
   logic wr_hi;
   logic wr_ctrl;
   logic sw_clear;
   logic [31:0] rd_mux;

   mcse_way_if #(.WAYS(WAYS)) way_bus ();

   assign way_bus.corr = cache_way_corr;
   assign way_bus.uncorr = cache_way_uncorr;
   assign way_bus.tag_hit = cache_way_tag_hit;
   assign cache_code = way_bus.code;

   mcse_l3_encoder #(.WAYS(WAYS)) u_l3_encoder (
      .ways(way_bus.enc)
   );

   // Cache error classification
   assign cache_none = (cache_code == MCSE_L3_NONE) ||
                       (cache_code == MCSE_L3_NONE_ALT); // [RL9]
   assign cache_corr = (cache_code == MCSE_L3_ONE_CORR) ||
                       (cache_code == MCSE_L3_MANY_CORR);
   assign cache_msc = {MCSE_L3_FIXED, MCSE_L3_RSVD, cache_code}; // [RL8]

   // Bus source decode; an out-of-range index would set a reserved bit in 31:28 or wrap to bit 16,
   // so such a report is dropped rather than logged half-formed
   assign src_ok = (bus_src <= MCSE_SRC_LAST); // [RL16]
   assign src_ecc = (bus_src == MCSE_SRC_IN_ECC);

   generate
      for (genvar gb = 0; gb < 16; gb++) begin : g_bus_bit
         // One index maps to one position; 19 and 31:28 are never hit
         assign bus_msc[gb] = src_ok &&
            (mcse_src_bit(bus_src) == 4'(gb)); // [RL12] [RL13] [RL14] [RL15] [RL16] [RL18]
      end
   endgenerate

   // Event acceptance and classification
   always_comb begin
      accept = 1'b0;
      new_uc = 1'b1;
      if (err_valid && ctrl_reg[MCSE_CTRL_LOG_EN_BIT]) begin
         if (err_kind == MCSE_KIND_CACHE) begin
            accept = !cache_none;
            new_uc = !cache_corr; // [RL19]
         end else begin
            accept = src_ok;
            new_uc = !(src_ecc && bus_corrected); // [RL17]
         end
      end
   end

   // Syndrome only for a correctable ECC-type event
   assign new_synv = syn_valid && !new_uc &&
      ((err_kind == MCSE_KIND_CACHE) || src_ecc); // [RL5]

   // Undefined formats are not advertised
   assign new_extra_info_valid = extra_info_valid &&
      (extra_info_format <= MCSE_FMT_LAST); // [RL3] [RL20]

   // Reserved health code and uncorrected events report no tracking;
   // the reserved code is the two defined ones ORed together
   always_comb begin
      if (new_uc ||
          (health_in == (MCSE_HEALTH_GREEN | MCSE_HEALTH_YELLOW))) begin
         new_health = MCSE_HEALTH_NONE; // [RL7]
      end else begin
         new_health = health_in; // [RL6]
      end
   end

   // A new report replaces an empty log, and an uncorrected one also replaces a corrected log; a logged
   // uncorrected error is kept so the first fatal cause is not lost
   assign overwrite = accept && (!val_reg || (new_uc && !uc_reg));

   // Avalon-MM: one wait state, answer on the second cycle
   assign bus_req = avs_read || avs_write;
   assign avs_waitrequest = bus_req && !ack_reg;
   assign bus_take = bus_req && ack_reg;
   assign avs_readdata = rdata_reg;

   assign wr_hi = bus_take && avs_write &&
      (avs_address == MCSE_OFF_STATUS_HI) && avs_byteenable[3];
   assign wr_ctrl = bus_take && avs_write &&
      (avs_address == MCSE_OFF_CTRL) && avs_byteenable[0];
   // Only the valid flag accepts a write, and only a zero
   assign sw_clear = wr_hi && !avs_writedata[MCSE_HI_VAL_BIT]; // [RL18]

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= bus_req && !ack_reg;
      end
   end

   always_comb begin
      case (avs_address)
         MCSE_OFF_STATUS_LO: rd_mux = bank4_error_status[31:0];
         MCSE_OFF_STATUS_HI: rd_mux = bank4_error_status[63:32];
         MCSE_OFF_CTRL: rd_mux = ctrl_reg;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_reg <= 32'h0000_0000;
      end else if (avs_read && !ack_reg) begin
         rdata_reg <= rd_mux;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_reg <= MCSE_CTRL_RESET;
      end else if (wr_ctrl) begin
         // Only the log-enable bit is writable
         ctrl_reg <= {31'h0, avs_writedata[MCSE_CTRL_LOG_EN_BIT]}; // [RL18]
      end
   end

   // Count survives software clears; only cold reset zeroes it
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         count_reg <= MCSE_COUNT_RESET;
      end else if (accept && !new_uc && (count_reg != MCSE_COUNT_MAX)) begin
         count_reg <= count_reg + 8'h01; // [RL2]
      end
   end

   // A new log wins over a clear in the same cycle
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         val_reg <= 1'b0;
      end else if (overwrite) begin
         val_reg <= 1'b1;
      end else if (sw_clear) begin
         val_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         uc_reg <= 1'b0;
      end else if (overwrite) begin
         uc_reg <= new_uc; // [RL19]
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         extra_info_valid_reg <= 1'b0;
      end else if (overwrite) begin
         extra_info_valid_reg <= new_extra_info_valid; // [RL20]
      end
   end

   // A layout is kept only with its valid flag, so no stale format shows
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         fmt_reg <= 2'h0;
      end else if (overwrite) begin
         fmt_reg <= new_extra_info_valid ? extra_info_format : 2'h0; // [RL3]
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         synv_reg <= 1'b0;
      end else if (overwrite) begin
         synv_reg <= new_synv; // [RL5]
      end
   end

   // A stale syndrome is zeroed so it cannot be mistaken for a new one
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         syn_reg <= 8'h00;
      end else if (overwrite) begin
         syn_reg <= new_synv ? syn_value : 8'h00; // [RL4]
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         health_reg <= MCSE_HEALTH_NONE;
      end else if (overwrite) begin
         health_reg <= new_health; // [RL6]
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         msc_reg <= 16'h0000;
      end else if (overwrite) begin
         if (err_kind == MCSE_KIND_CACHE) begin
            msc_reg <= cache_msc; // [RL8]
         end else begin
            msc_reg <= bus_msc; // [RL16]
         end
      end
   end

   // Status assembly; unowned bits (15:0, 43:42, 56:55, 57, 58, 60, 62)
   // read zero
   always_comb begin
      bank4_error_status = 64'h0000_0000_0000_0000; // [RL18]
      bank4_error_status[MCSE_CODE_LSB +: 16] = msc_reg;
      bank4_error_status[MCSE_COUNT_LSB +: 8] = count_reg; // [RL1] [RL2]
      bank4_error_status[MCSE_FMT_LSB +: 2] = fmt_reg; // [RL3]
      bank4_error_status[MCSE_SYN_LSB +: 8] = syn_reg; // [RL4]
      bank4_error_status[MCSE_SYNV_BIT] = synv_reg; // [RL5]
      // Health only shown while the log is valid
      bank4_error_status[MCSE_HEALTH_LSB +: 2] =
         val_reg ? health_reg : MCSE_HEALTH_NONE; // [RL7]
      bank4_error_status[MCSE_EXTRA_INFO_VALID_BIT] = extra_info_valid_reg; // [RL20]
      bank4_error_status[MCSE_UC_BIT] = uc_reg; // [RL19]
      bank4_error_status[MCSE_VAL_BIT] = val_reg;
   end
endmodule

//--- design/mcse_pkg.sv
// Constants and types for the machine-check status encoder
package mcse_pkg;
   // Register byte offsets
   localparam logic [3:0] MCSE_OFF_STATUS_LO = 4'h0;
   localparam logic [3:0] MCSE_OFF_STATUS_HI = 4'h4;
   localparam logic [3:0] MCSE_OFF_CTRL = 4'h8;
   localparam logic [31:0] MCSE_CTRL_RESET = 32'h0000_0001;
   localparam int MCSE_CTRL_LOG_EN_BIT = 0;
   localparam int MCSE_HI_VAL_BIT = 31;
   // Field positions in the 64-bit status word
   localparam int MCSE_CODE_LSB = 16;
   localparam int MCSE_COUNT_LSB = 32;
   localparam int MCSE_FMT_LSB = 40;
   localparam int MCSE_SYN_LSB = 44;
   localparam int MCSE_SYNV_BIT = 52;
   localparam int MCSE_HEALTH_LSB = 53;
   localparam int MCSE_EXTRA_INFO_VALID_BIT = 59;
   localparam int MCSE_UC_BIT = 61;
   localparam int MCSE_VAL_BIT = 63;
   // Counter
   localparam logic [7:0] MCSE_COUNT_RESET = 8'h00;
   localparam logic [7:0] MCSE_COUNT_MAX = 8'hff;
   // Cache error code field
   localparam logic [10:0] MCSE_L3_FIXED = 11'b0010_0000_000;
   localparam logic [1:0] MCSE_L3_RSVD = 2'h0;
   localparam logic [2:0] MCSE_L3_NONE = 3'h0;
   localparam logic [2:0] MCSE_L3_MANY_CORR = 3'h1;
   localparam logic [2:0] MCSE_L3_MANY_UNCORR = 3'h2;
   localparam logic [2:0] MCSE_L3_MANY_TAG = 3'h3;
   localparam logic [2:0] MCSE_L3_NONE_ALT = 3'h4;
   localparam logic [2:0] MCSE_L3_ONE_CORR = 3'h5;
   localparam logic [2:0] MCSE_L3_ONE_UNCORR = 3'h6;
   localparam logic [2:0] MCSE_L3_MIXED = 3'h7;
   // Threshold health
   localparam logic [1:0] MCSE_HEALTH_NONE = 2'h0;
   localparam logic [1:0] MCSE_HEALTH_GREEN = 2'h1;
   localparam logic [1:0] MCSE_HEALTH_YELLOW = 2'h2;
   // Extra-info formats defined so far
   localparam logic [1:0] MCSE_FMT_LAST = 2'h1;

   typedef enum logic {
      MCSE_KIND_CACHE,
      MCSE_KIND_BUS
   } mcse_kind_e;

   typedef enum logic [3:0] {
      MCSE_SRC_REQ_PAR,
      MCSE_SRC_CORE0_ADDR,
      MCSE_SRC_CORE1_ADDR,
      MCSE_SRC_RSP_PAR,
      MCSE_SRC_DATA_PAR,
      MCSE_SRC_CORE0_DATA,
      MCSE_SRC_CORE1_DATA,
      MCSE_SRC_DEFER_PAR,
      MCSE_SRC_IN_ECC,
      MCSE_SRC_DATA_GLITCH,
      MCSE_SRC_ADDR_GLITCH
   } mcse_bus_src_e;

   localparam logic [3:0] MCSE_SRC_LAST = 4'ha;
   localparam logic [3:0] MCSE_SRC_GAP = 4'h3;

   // Bit offset within the code field; offset 3 is skipped
   function automatic logic [3:0] mcse_src_bit(input logic [3:0] src);
      mcse_src_bit = (src < MCSE_SRC_GAP) ? src : 4'(src + 4'h1);
   endfunction
endpackage

//--- design/mcse_way_if.sv
// Per-way cache reports and the resulting cache error code
`timescale 1ns/1ps
interface mcse_way_if #(parameter int WAYS = 8);
   logic [WAYS-1:0] corr;
   logic [WAYS-1:0] uncorr;
   logic [WAYS-1:0] tag_hit;
   logic [2:0] code;
   modport enc (input corr, input uncorr, input tag_hit, output code);
   modport top (output corr, output uncorr, output tag_hit, input code);
endinterface

//--- design/mcse_l3_encoder.sv
// Encodes per-way cache reports into the 3-bit cache error code
`timescale 1ns/1ps
module mcse_l3_encoder
   import mcse_pkg::*;
#(
   parameter int WAYS = 8
) (
   // Way reports in, code out
   mcse_way_if.enc ways
);
   logic any_corr;
   logic any_unc;
   logic many_corr;
   logic many_unc;
   logic many_tag;

   // A vector has two or more bits set when clearing its lowest one leaves some
   assign any_corr = |ways.corr;
   assign any_unc = |ways.uncorr;
   assign many_corr = |(ways.corr & (ways.corr - 1'b1));
   assign many_unc = |(ways.uncorr & (ways.uncorr - 1'b1));
   assign many_tag = |(ways.tag_hit & (ways.tag_hit - 1'b1));

   always_comb begin
      if (any_corr && any_unc) begin
         ways.code = MCSE_L3_MIXED; // [RL11]
      end else if (many_unc) begin
         ways.code = MCSE_L3_MANY_UNCORR; // [RL9]
      end else if (any_unc) begin
         ways.code = MCSE_L3_ONE_UNCORR; // [RL10]
      end else if (many_tag) begin
         ways.code = MCSE_L3_MANY_TAG; // [RL9]
      end else if (many_corr) begin
         ways.code = MCSE_L3_MANY_CORR; // [RL9]
      end else if (any_corr) begin
         ways.code = MCSE_L3_ONE_CORR; // [RL10]
      end else begin
         ways.code = MCSE_L3_NONE; // [RL9]
      end
   end
endmodule

//--- verif/mcse_status_assertions.sv
// Port-level checker for the machine-check status encoder
`timescale 1ns/1ps
module mcse_status_assertions
   import mcse_pkg::*;
#(
   parameter int WAYS = 8
) (
   // Clock and reset
   input logic core_clk,
   input logic arst_n,
   // Register bus and status
   input logic avs_read,
   input logic avs_write,
   input logic avs_waitrequest,
   input logic [63:0] bank4_error_status
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   logic [63:0] s;
   logic is_l3;
   assign s = bank4_error_status;
   // Bus codes never reach bit 29, so the fixed pattern marks a cache log
   assign is_l3 = s[31:21] == MCSE_L3_FIXED;

   count_sat_a: assert property (s[39:32] == MCSE_COUNT_MAX |=> s[39:32] == MCSE_COUNT_MAX)
      else $error("count left saturation");
   count_step_a: assert property ($changed(s[39:32]) |-> s[39:32] == $past(s[39:32]) + 8'h01)
      else $error("count moved by other than one");
   rsvd_zero_a: assert property (s[43:42] == 2'h0 && s[56:55] == 2'h0 && !s[19])
      else $error("reserved bit set");
   bus_onehot_a: assert property (s[63] && !is_l3 |-> $onehot(s[27:16]) && s[31:28] == 4'h0)
      else $error("bus code not one-hot");
   bus_corr_a: assert property (s[63] && !is_l3 && !s[61] |-> s[25])
      else $error("corrected bus error not inbound ecc");
   l3_code_a: assert property (s[63] && is_l3 |-> s[20:19] == 2'h0 && s[17:16] != 2'h0)
      else $error("cache code malformed");
   l3_corr_a: assert property (s[63] && is_l3 |-> s[61] == (s[17:16] != 2'h1))
      else $error("cache code and uncorrected flag disagree");
   health_zero_a: assert property (!s[63] || s[61] || s[54:53] == 2'h3 |-> s[54:53] == 2'h0)
      else $error("health shown while invalid");
   synv_corr_a: assert property (s[52] |-> !s[61] && (s[63] || $stable(s[52])))
      else $error("syndrome valid on uncorrected or unlogged event");
   fmt_field_a: assert property (s[41:40] <= MCSE_FMT_LAST && (s[59] || s[41:40] == 2'h0))
      else $error("format field bad");
   wait_once_a: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("waitrequest not one cycle");
endmodule
bind mcse_status_encoder mcse_status_assertions #(.WAYS(WAYS)) u_chk (.core_clk(core_clk),
   .arst_n(arst_n), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .bank4_error_status(bank4_error_status));

//--- verif/tb_top.sv
// Self-checking bench for the machine-check status encoder
`timescale 1ns/1ps
module tb_top
   import mcse_pkg::*;
;
   logic core_clk, arst_n, avs_read, avs_write, avs_waitrequest, err_valid;
   logic bus_corrected, syn_valid, extra_info_valid;
   logic [3:0] avs_address, avs_byteenable, bus_src;
   logic [31:0] avs_writedata, avs_readdata, q;
   mcse_kind_e err_kind;
   logic [7:0] cache_way_corr, cache_way_uncorr, cache_way_tag_hit, syn_value, cnt;
   logic [1:0] extra_info_format, health_in;
   logic [63:0] st;
   int errors, total_checks, cyc;

   mcse_status_encoder #(.WAYS(8)) u_dut (.core_clk(core_clk), .arst_n(arst_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .err_valid(err_valid),
      .err_kind(err_kind), .cache_way_corr(cache_way_corr), .cache_way_uncorr(cache_way_uncorr),
      .cache_way_tag_hit(cache_way_tag_hit), .bus_src(bus_src), .bus_corrected(bus_corrected),
      .syn_valid(syn_valid), .syn_value(syn_value), .extra_info_valid(extra_info_valid),
      .extra_info_format(extra_info_format), .health_in(health_in), .bank4_error_status(st));

   task automatic final_report();
      if (errors == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
      @(posedge core_clk);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   // Drops the valid flag so the next accepted report is always stored
   task automatic clr();
      av(1'b1, MCSE_OFF_STATUS_HI, 32'h0, 4'h8);
   endtask

   task automatic rep(input mcse_kind_e k, input logic [3:0] src, input logic [7:0] c,
                      input logic [7:0] u, input logic [7:0] t);
      @(posedge core_clk);
      err_valid <= 1'b1;
      err_kind <= k;
      bus_src <= src;
      cache_way_corr <= c;
      cache_way_uncorr <= u;
      cache_way_tag_hit <= t;
      @(posedge core_clk);
      err_valid <= 1'b0;
      #1;
   endtask

   task automatic t_regs();
      av(1'b0, MCSE_OFF_CTRL, 32'h0, 4'hf);
      check("ctrl", q, MCSE_CTRL_RESET);
      av(1'b1, 4'hc, 32'hffff_ffff, 4'hf);
      av(1'b0, 4'hc, 32'h0, 4'hf);
      check("unmapped", q, 64'h0);
      av(1'b0, MCSE_OFF_STATUS_HI, 32'h0, 4'hf);
      check("hi reset", q, 64'h0);
   endtask

   task automatic t_bus();
      logic ok;
      int b;
      @(posedge core_clk);
      syn_valid <= 1'b1;
      health_in <= 2'h2;
      extra_info_valid <= 1'b1;
      extra_info_format <= 2'h1;
      bus_corrected <= 1'b1;
      for (int i = 0; i < 11; i++) begin
         clr();
         syn_value <= 8'h30 + 8'(i);
         rep(MCSE_KIND_BUS, 4'(i), 8'h0, 8'h0, 8'h0);
         ok = (i == 8);
         cnt = cnt + 8'(ok);
         b = (i < 3) ? i : i + 1;
         check("bus code", st[31:16], 64'h1 << b);
         check("bus uc", {st[63], st[61]}, {1'b1, !ok});
         check("bus info", {st[59], st[54:52], st[41:32]}, {1'b1, ok, 1'b0, ok, 2'h1, cnt});
         if (ok) check("syndrome", st[51:44], 8'h38);
      end
      clr();
      rep(MCSE_KIND_BUS, 4'hb, 8'h0, 8'h0, 8'h0);
      check("bad src", st[63], 1'b0);
   endtask

   task automatic t_cache();
      logic [7:0] c[7] = '{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
      logic [7:0] u[7] = '{8'h00, 8'h00, 8'h04, 8'h0c, 8'h00, 8'h02, 8'h00};
      logic [7:0] t[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h30, 8'h00, 8'h10};
      logic [2:0] e[7] = '{3'h5, 3'h1, 3'h6, 3'h2, 3'h3, 3'h7, 3'h0};
      logic ok;
      @(posedge core_clk);
      health_in <= 2'h3;
      extra_info_format <= 2'h2;
      for (int i = 0; i < 7; i++) begin
         clr();
         rep(MCSE_KIND_CACHE, 4'h0, c[i], u[i], t[i]);
         ok = (e[i] == 3'h1 || e[i] == 3'h5);
         cnt = cnt + 8'(ok);
         if (i == 6) check("single tag", st[63], 1'b0);
         else begin
            check("l3 code", st[31:16], {MCSE_L3_FIXED, 2'b00, e[i]});
            check("l3 uc", st[61], !ok);
         end
         check("l3 info", {st[59], st[54:52], st[41:32]}, {3'b000, ok, 2'h0, cnt});
      end
   endtask

   task automatic t_sat();
      @(posedge core_clk);
      err_valid <= 1'b1;
      err_kind <= MCSE_KIND_BUS;
      bus_src <= 4'h8;
      repeat (260) @(posedge core_clk);
      err_valid <= 1'b0;
      #1;
      check("saturated", st[39:32], MCSE_COUNT_MAX);
   endtask

   task automatic t_sw();
      logic [63:0] old;
      old = st;
      av(1'b0, MCSE_OFF_STATUS_LO, 32'h0, 4'hf);
      check("lo read", q, old[31:0]);
      av(1'b0, MCSE_OFF_STATUS_HI, 32'h0, 4'hf);
      check("hi read", q, old[63:32]);
      av(1'b1, MCSE_OFF_STATUS_HI, 32'h7fff_ffff, 4'hf);
      av(1'b1, MCSE_OFF_STATUS_HI, 32'hffff_ffff, 4'hf);
      #1;
      check("hi write", st[63:32], old[63:32] & 32'h7f9f_ffff);
      av(1'b1, MCSE_OFF_CTRL, 32'h0, 4'he);
      av(1'b0, MCSE_OFF_CTRL, 32'h0, 4'hf);
      check("ctrl lane", q, MCSE_CTRL_RESET);
      av(1'b1, MCSE_OFF_CTRL, 32'h0, 4'h1);
      rep(MCSE_KIND_BUS, 4'h0, 8'h0, 8'h0, 8'h0);
      check("log off", {st[63], st[61]}, 2'b00);
      av(1'b1, MCSE_OFF_CTRL, 32'h1, 4'h1);
      syn_valid <= 1'b0;
      health_in <= MCSE_HEALTH_GREEN;
      rep(MCSE_KIND_BUS, 4'h8, 8'h0, 8'h0, 8'h0);
      check("green", {st[63], st[61], st[54:52], st[51:44]}, {2'b10, 3'b010, 8'h00});
      rep(MCSE_KIND_BUS, 4'h0, 8'h0, 8'h0, 8'h0);
      rep(MCSE_KIND_BUS, 4'h8, 8'h0, 8'h0, 8'h0);
      check("kept uc", {st[61], st[54:53], st[31:16]}, {3'b100, 16'h0001});
   endtask

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         final_report();
      end
   end

   initial begin
      {arst_n, avs_read, avs_write, err_valid, bus_corrected, syn_valid, extra_info_valid} = '0;
      {avs_address, avs_byteenable, bus_src, avs_writedata, syn_value, cnt} = '0;
      {cache_way_corr, cache_way_uncorr, cache_way_tag_hit, extra_info_format, health_in} = '0;
      err_kind = MCSE_KIND_CACHE;
      repeat (20) @(posedge core_clk);
      arst_n <= 1'b1;
      t_regs();
      t_bus();
      t_cache();
      t_sat();
      t_sw();
      final_report();
   end
endmodule
